// ===== baud_rate_regs.sv
// APB register block for baud divisor and shared frame format view
// Function
// - high divisor byte and frame control share one address, view bit picks writes, read_high_view picks reads.
// - reading the high byte view returns the view select bit as zero.
// - the 12-bit divisor is high nibble over the low byte.
// - a low byte write reloads the prescaler at once.
// - double speed with the async mode bit clear cuts the oversample divider from 16 to 8.
// - the control view reads the view bit as one; writes to it set it.
`timescale 1ns/100ps
module baud_rate_regs
  import baud_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // rate outputs
  output logic baud_tick,
  output logic bit_tick,
  output logic [11:0] baud_divisor,
  output logic [7:0] frame_format_control
);
  `include "baud_defines.svh"

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [3:0] div_high;
  logic [7:0] div_low;
  logic read_high_view;
  logic reload;
  acc_state_type state;
  logic [3:0] next_div_high;
  logic [7:0] next_div_low;
  logic [7:0] next_ctrl;
  logic next_read_high_view;
  logic next_reload;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  acc_state_type next_state;
  rate_out_type rate;
  logic double_speed;

  function automatic logic [11:0] join_divisor(input logic [3:0] hi,
                                               input logic [7:0] lo);
    join_divisor = {hi, lo};
  endfunction

  // double speed counts only while the async mode bit is clear
  assign double_speed = frame_format_control[`DOUBLE_SPEED_BIT]
                        && !frame_format_control[`ASYNC_MODE_BIT];

  // ------------------------------------------------------------
  // apb access
  // ------------------------------------------------------------
  always_comb begin
    next_div_high = div_high;
    next_div_low = div_low;
    next_ctrl = frame_format_control;
    next_read_high_view = read_high_view;
    next_reload = 1'b0;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_state = ACC_IDLE;
    unique case (state)
      ACC_IDLE: begin
        if (psel && !penable) begin
          next_state = ACC_DONE;
          next_pready = 1'b1;
          next_prdata = 32'h0000_0000;
          // setup cycle: read data and error for the access phase
          unique case (paddr)
            `OFS_SHARED: begin
              if (!pwrite && read_high_view) begin
                next_prdata = {28'h000_0000, div_high};
              end else if (!pwrite) begin
                next_prdata = {24'h00_0000, frame_format_control};
              end
            end
            `OFS_DIV_LOW: begin
              if (!pwrite) begin
                next_prdata = {24'h00_0000, div_low};
              end
            end
            `OFS_STATUS: begin
              if (!pwrite) begin
                next_prdata = {31'h0000_0000, read_high_view};
              end
            end
            default: next_pslverr = 1'b1;
          endcase
        end
      end
      ACC_DONE: begin
        // writes land on the edge that completes the access phase
        if (psel && penable && pwrite) begin
          unique case (paddr)
            `OFS_SHARED: begin
              if (pwdata[`VIEW_SEL_BIT]) begin
                next_ctrl = pwdata[7:0];
                next_ctrl[`VIEW_SEL_BIT] = 1'b1;
              end else begin
                next_div_high = pwdata[3:0];
              end
            end
            `OFS_DIV_LOW: begin
              next_div_low = pwdata[7:0];
              next_reload = 1'b1;
            end
            `OFS_STATUS: begin
              next_read_high_view = pwdata[0];
            end
            // unmapped: nothing changes
            default: next_reload = 1'b0;
          endcase
        end
      end
      default: next_state = ACC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_high <= `DIV_HIGH_RESET;
      div_low <= `DIV_LOW_RESET;
      frame_format_control <= `FRAME_CTRL_RESET;
      read_high_view <= 1'b0;
      reload <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      state <= ACC_IDLE;
      baud_tick <= 1'b0;
      bit_tick <= 1'b0;
      baud_divisor <= 12'h000;
    end else if (clk_en) begin
      div_high <= next_div_high;
      div_low <= next_div_low;
      frame_format_control <= next_ctrl;
      read_high_view <= next_read_high_view;
      reload <= next_reload;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      state <= next_state;
      baud_tick <= rate.tick;
      bit_tick <= rate.bit_tick;
      baud_divisor <= rate.divisor;
    end
  end

  // ------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------
  baud_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .reload(reload),
    .divisor(join_divisor(div_high, div_low)),
    .double_speed(double_speed),
    .rate(rate)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_low_write;
    psel && penable && pwrite && paddr == `OFS_DIV_LOW && clk_en
      && state == ACC_DONE;
  endsequence

  sequence s_shared_write;
    psel && penable && pwrite && paddr == `OFS_SHARED && clk_en
      && state == ACC_DONE;
  endsequence

  sequence s_shared_read;
    psel && !penable && !pwrite && paddr == `OFS_SHARED && clk_en
      && state == ACC_IDLE;
  endsequence

  AST_LOW_RELOAD: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_low_write |=> reload && div_low == $past(pwdata[7:0]))
    else $error("low byte write did not request reload");
  AST_HIGH_READ_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_shared_read ##0 read_high_view
    |=> prdata[`VIEW_SEL_BIT] == 1'b0 && prdata[3:0] == $past(div_high))
    else $error("high view read shows view bit set");
  AST_CTRL_VIEW_ONE: assert property (
    @(posedge pclk) disable iff (!presetn)
    frame_format_control[`VIEW_SEL_BIT])
    else $error("control view bit not one");
  AST_HIGH_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_shared_write ##0 !pwdata[`VIEW_SEL_BIT]
    |=> div_high == $past(pwdata[3:0]) && $stable(frame_format_control))
    else $error("high byte write misrouted");
  AST_CTRL_WRITE: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_shared_write ##0 pwdata[`VIEW_SEL_BIT]
    |=> frame_format_control == {1'b1, $past(pwdata[6:0])}
      && $stable(div_high))
    else $error("control view write misrouted");
  AST_DIVISOR_JOIN: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && $past(clk_en)
    |=> baud_divisor == $past(join_divisor(div_high, div_low), 2))
    else $error("divisor not high nibble over low byte");
endmodule

// ===== baud_defines.svh
// register offsets, field positions, reset values for the baud block
`ifndef BAUD_DEFINES_SVH
`define BAUD_DEFINES_SVH
`define OFS_SHARED 12'h000
`define OFS_DIV_LOW 12'h004
`define OFS_STATUS 12'h008
`define VIEW_SEL_BIT 7
`define DOUBLE_SPEED_BIT 1
`define ASYNC_MODE_BIT 6
`define FRAME_CTRL_RESET 8'h86
`define DIV_HIGH_RESET 4'h0
`define DIV_LOW_RESET 8'h00
`define OVERSAMPLE_NORMAL 5'h10
`define OVERSAMPLE_DOUBLE 5'h08
`define PREADY_CYCLES 1
`endif

// ===== baud_pkg.sv
// types shared by the baud rate block
package baud_pkg;
  typedef struct packed {
    logic tick;
    logic bit_tick;
    logic [11:0] divisor;
  } rate_out_type;
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_DONE
  } acc_state_type;
endpackage

// ===== baud_prescaler.sv
// baud prescaler down-counter and oversample divider
`timescale 1ns/100ps
module baud_prescaler
  import baud_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // control
  input wire logic reload,
  input wire logic [11:0] divisor,
  input wire logic double_speed,
  // rate ticks
  output rate_out_type rate
);
  `include "baud_defines.svh"
  logic [11:0] count;
  logic [4:0] sub;
  logic [11:0] next_count;
  logic [4:0] next_sub;
  rate_out_type next_rate;

  always_comb begin
    next_count = count;
    next_sub = sub;
    next_rate = rate;
    next_rate.tick = 1'b0;
    next_rate.bit_tick = 1'b0;
    next_rate.divisor = divisor;
    if (reload) begin
      next_count = divisor;
      next_sub = 5'h00;
    end else if (count == 12'h000) begin
      next_count = divisor;
      next_rate.tick = 1'b1;
      if (sub + 5'h01 >= (double_speed ? `OVERSAMPLE_DOUBLE
          : `OVERSAMPLE_NORMAL)) begin
        next_sub = 5'h00;
        next_rate.bit_tick = 1'b1;
      end else begin
        next_sub = sub + 5'h01;
      end
    end else begin
      next_count = count - 12'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 12'h000;
      sub <= 5'h00;
      rate <= '0;
    end else if (clk_en) begin
      count <= next_count;
      sub <= next_sub;
      rate <= next_rate;
    end
  end

  AST_RELOAD_NOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && reload |=> count == $past(divisor))
    else $error("prescaler not reloaded on low byte write");
  AST_TICK_AT_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !reload && count == 12'h000 |=> rate.tick)
    else $error("no tick at count zero");
  AST_DOUBLE_WRAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    clk_en && !reload && count == 12'h000 && double_speed
    && sub == 5'h07 |=> rate.bit_tick)
    else $error("double speed wrap not at eight");
endmodule

// ===== test_baud_rate_regs.sv
// self-checking testbench for the baud rate register block
`timescale 1ns/100ps
module test_baud_rate_regs;
  import baud_pkg::*;
  logic pclk = 0, presetn = 0, clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, baud_tick, bit_tick;
  logic [11:0] baud_divisor;
  logic [7:0] frame_format_control;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [3:0] hi;
  logic [7:0] lo;
  logic [12:0] snap;
  int failures = 0, comparisons = 0;
  int gap = 0, bits = 0, arm = 0, per = 0, bper = 0, seen = 0, n;

  always #5 pclk = ~pclk;

  baud_rate_regs DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .baud_tick(baud_tick), .bit_tick(bit_tick), .baud_divisor(baud_divisor),
    .frame_format_control(frame_format_control));

  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task cmp_bus(input logic [33:0] ex);
    cmp("pslverr", {31'h0, ex[32]}, {31'h0, pslverr});
    if (ex[33]) cmp("prdata", ex[31:0], prdata);
  endtask

  task stop_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------
  // apb master
  // ----------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [33:0] ex);
    exp_q.push_back(ex);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      stop_test;
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(1, a, d, {1'b0, err, 32'h0000_0000});
  endtask

  task rd(input logic [11:0] a, input logic [31:0] d, input logic err);
    apb(0, a, 32'h0000_0000, {1'b1, err, d});
  endtask

  task window(input int p, input int bp);
    per = p;
    bper = bp;
    repeat (150) @(posedge pclk);
    seen = 0;
    arm = 1;
    repeat (400) @(posedge pclk);
    arm = 0;
    cmp("ticks seen", 1, {31'h0, seen >= 400 / p - 1});
  endtask

  // ----------------------------------------
  // response and tick monitors
  // ----------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) cmp("unexpected answer", 0, 1);
      else begin
        e = exp_q.pop_front();
        cmp_bus(e);
      end
    end
  end

  always @(negedge pclk) begin
    gap++;
    if (baud_tick === 1'b1) begin
      if (arm) cmp("baud period", per, gap);
      if (arm) seen++;
      gap = 0;
      bits++;
    end
    if (bit_tick === 1'b1) begin
      if (arm) cmp("bit period", bper, bits);
      bits = 0;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(83849));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    cmp("control reset", 32'h0000_0086,
        {24'h0, frame_format_control});
    cmp("divisor reset", 32'h0000_0000, {20'h0, baud_divisor});
    rd(12'h000, 32'h0000_0086, 0);
    hi = 4'($urandom);
    lo = 8'($urandom);
    wr(12'h000, {24'h0, 4'h0, hi}, 0);
    wr(12'h004, {24'h0, lo}, 0);
    repeat (3) @(posedge pclk);
    cmp("divisor", {20'h0, hi, lo}, {20'h0, baud_divisor});
    wr(12'h008, 32'h0000_0001, 0);
    rd(12'h000, {28'h0, hi}, 0);
    rd(12'h004, {24'h0, lo}, 0);
    wr(12'h008, 32'h0000_0000, 0);
    wr(12'h000, 32'h0000_0082, 0);
    rd(12'h000, 32'h0000_0082, 0);
    cmp("divisor kept", {20'h0, hi, lo}, {20'h0, baud_divisor});
    cmp("control", 32'h0000_0082, {24'h0, frame_format_control});
    rd(12'h00C, 32'h0000_0000, 1);
    wr(12'h00C, 32'h0000_00FF, 1);
    wr(12'h000, 32'h0000_0000, 0);
    wr(12'h004, 32'h0000_0003, 0);
    wr(12'h000, 32'h0000_0082, 0);
    window(4, 8);
    wr(12'h000, 32'h0000_0084, 0);
    window(4, 16);
    wr(12'h000, 32'h0000_00C2, 0);
    window(4, 16);
    wr(12'h004, 32'h0000_00FF, 0);
    repeat (20) @(posedge pclk);
    wr(12'h004, 32'h0000_0002, 0);
    for (n = 0; n < 8 && baud_tick !== 1'b1; n++) @(negedge pclk);
    cmp("reload tick", 1, {31'h0, n < 8});
    // clock enable low must freeze ticks and divisor
    @(posedge pclk);
    clk_en <= 1'b0;
    repeat (2) @(negedge pclk);
    snap = {baud_tick, baud_divisor};
    seen = 0;
    repeat (20) begin
      @(negedge pclk);
      if ({baud_tick, baud_divisor} !== snap) seen++;
    end
    cmp("frozen changes", 0, seen);
    cmp("answers left", 0, exp_q.size());
    stop_test;
  end

  initial begin
    #200000;
    failures++;
    stop_test;
  end
endmodule
